// file: rtl/asdf_adc_ctrl.sv
// Audio delta-sigma converter control: decimator, FIFO, APB registers
`default_nettype none
module asdf_adc_ctrl
  import asdf_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modulator
  input wire logic modulator_bit,
  output logic modulator_clock,
  // Biquad path
  output logic bq_valid,
  output logic [15:0] bq_data,
  input wire logic bq_ret_valid,
  input wire logic [15:0] bq_ret_data,
  // Interrupts and DMA
  output logic fifo_irq,
  output logic cmp0_irq,
  output logic cmp1_irq,
  output logic dma_req
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic [8:0] osr_of(input logic [3:0] sel);
    logic [8:0] r;
    r = OSR_64;
    unique case (sel)
      4'h1: r = OSR_128;
      4'h2: r = OSR_192;
      4'h3: r = OSR_384;
      default: r = OSR_64;
    endcase
    return r;
  endfunction

  // Ones count centred at zero and scaled toward full 16-bit range
  function automatic logic [15:0] scale(input logic [8:0] ones,
                                        input logic [3:0] sel);
    logic [15:0] d;
    logic [8:0] half;
    logic [16:0] s;
    half = osr_of(sel) >> 1;
    d = {7'h00, ones} - {7'h00, half};
    unique case (sel)
      4'h1: s = {d[15], d} << 9;
      4'h2: s = {d[15], d} << 8;
      4'h3: s = {d[15], d} << 7;
      default: s = {d[15], d} << 10;
    endcase
    // At ratios 64 and 128 full-scale positive would otherwise wrap to the most negative code
    if (s[16] != s[15]) begin
      scale = s[16] ? 16'h8000 : 16'h7fff;
    end else begin
      scale = s[15:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  asdf_state_t st;
  asdf_state_t next_st;
  logic setup;
  logic rd_data;
  logic pop_ok;
  logic push;
  logic [15:0] push_data;
  logic tick;
  logic [8:0] ones_now;
  logic [31:0] rdv;

  assign setup = psel && !penable;
  assign rd_data = setup && !pwrite && paddr == OFS_FIFO_READ;
  assign pop_ok = rd_data && st.cnt != 4'h0;
  assign tick = st.regs.conv_en && st.div_cnt == st.regs.clk_div - 8'h01;
  assign ones_now = st.ones + {8'h00, st.bit_s2};

  always_comb begin
    next_st = st;
    push = 1'b0;
    push_data = 16'h0000;
    rdv = 32'h0000_0000;
    next_st.outs.pready = setup;
    next_st.outs.bq_valid = 1'b0;
    next_st.bit_s1 = modulator_bit;
    next_st.bit_s2 = st.bit_s1;

    // -------------------------------------------------------------
    // Modulator clock divider
    // -------------------------------------------------------------
    // modulator clock divide
    if (!st.regs.conv_en || tick) begin
      next_st.div_cnt = 8'h00;
    end else begin
      next_st.div_cnt = st.div_cnt + 8'h01;
    end
    next_st.outs.modulator_clock = st.regs.conv_en &&
      (next_st.div_cnt < (st.regs.clk_div >> 1));

    // -------------------------------------------------------------
    // Decimator
    // -------------------------------------------------------------
    // count ones per frame
    if (tick) begin
      if (st.bit_cnt == osr_of(st.regs.osr_sel) - 9'h001) begin
        next_st.bit_cnt = 9'h000;
        next_st.ones = 9'h000;
        if (st.regs.bq_sel) begin
          next_st.outs.bq_valid = 1'b1;
          next_st.outs.bq_data = scale(ones_now, st.regs.osr_sel);
        end else begin
          push = 1'b1;
          push_data = scale(ones_now, st.regs.osr_sel);
        end
      end else begin
        next_st.bit_cnt = st.bit_cnt + 9'h001;
        next_st.ones = ones_now;
      end
    end
    if (st.regs.bq_sel && bq_ret_valid) begin
      push = 1'b1;
      push_data = bq_ret_data;
    end

    // -------------------------------------------------------------
    // FIFO
    // -------------------------------------------------------------
    // pop oldest sample
    if (pop_ok) begin
      next_st.last = st.mem[st.rp];
    end
    if (push) begin
      next_st.mem[st.wp] = push_data;
      next_st.wp = st.wp + 3'h1;
    end
    if (pop_ok || (push && st.cnt == FIFO_FULL)) begin
      next_st.rp = st.rp + 3'h1;
    end
    if (push && !pop_ok && st.cnt != FIFO_FULL) begin
      next_st.cnt = st.cnt + 4'h1;
    end else if (!push && pop_ok) begin
      next_st.cnt = st.cnt - 4'h1;
    end

    // -------------------------------------------------------------
    // Register access
    // -------------------------------------------------------------
    // register decode
    unique case (paddr)
      OFS_FIFO_READ: begin
        rdv = {16'h0000, pop_ok ? st.mem[st.rp] : st.last};
      end
      OFS_CONV_EN: rdv[CONV_EN_BIT] = st.regs.conv_en;
      OFS_CLK_DIV: rdv[DIV_LSB +: 8] = st.regs.clk_div;
      OFS_DEC_CTL: begin
        rdv[OSR_LSB +: 4] = st.regs.osr_sel;
        rdv[BQ_SEL_BIT] = st.regs.bq_sel;
      end
      OFS_INT_CTL: begin
        rdv[IRQ_EN_BIT] = st.regs.irq_en;
        rdv[THR_LSB +: 3] = st.regs.thr;
      end
      OFS_DMA_CTL: rdv[RX_EN_BIT] = st.regs.rx_en;
      OFS_CMP0: begin
        rdv[CMP_EN_BIT] = st.regs.cmp0_en;
        rdv[CMP_LVL_LSB +: 16] = st.regs.cmp0_lvl;
      end
      OFS_CMP1: begin
        rdv[CMP_EN_BIT] = st.regs.cmp1_en;
        rdv[CMP_LVL_LSB +: 16] = st.regs.cmp1_lvl;
      end
      default: rdv = 32'h0000_0000;
    endcase
    if (setup) begin
      next_st.outs.pslverr = paddr > OFS_LAST || paddr[1:0] != 2'b00;
      if (!pwrite) begin
        next_st.outs.prdata = rdv;
      end
    end
    if (setup && pwrite) begin
      unique case (paddr)
        OFS_CONV_EN: next_st.regs.conv_en = pwdata[CONV_EN_BIT];
        OFS_CLK_DIV: next_st.regs.clk_div = pwdata[DIV_LSB +: 8];
        OFS_DEC_CTL: begin
          next_st.regs.osr_sel = pwdata[OSR_LSB +: 4];
          next_st.regs.bq_sel = pwdata[BQ_SEL_BIT];
          // A new ratio starts a fresh frame so the count cannot overshoot
          next_st.bit_cnt = 9'h000;
          next_st.ones = 9'h000;
        end
        OFS_INT_CTL: begin
          next_st.regs.irq_en = pwdata[IRQ_EN_BIT];
          next_st.regs.thr = pwdata[THR_LSB +: 3];
        end
        OFS_DMA_CTL: next_st.regs.rx_en = pwdata[RX_EN_BIT];
        OFS_CMP0: begin
          next_st.regs.cmp0_en = pwdata[CMP_EN_BIT];
          next_st.regs.cmp0_lvl = pwdata[CMP_LVL_LSB +: 16];
        end
        OFS_CMP1: begin
          next_st.regs.cmp1_en = pwdata[CMP_EN_BIT];
          next_st.regs.cmp1_lvl = pwdata[CMP_LVL_LSB +: 16];
        end
        default: next_st.regs = next_st.regs;
      endcase
    end

    if (!st.regs.conv_en) begin
      next_st.wp = 3'h0;
      next_st.rp = 3'h0;
      next_st.cnt = 4'h0;
      next_st.bit_cnt = 9'h000;
      next_st.ones = 9'h000;
    end

    // -------------------------------------------------------------
    // Interrupts and DMA request
    // -------------------------------------------------------------
    // level interrupt
    next_st.outs.fifo_irq = next_st.regs.irq_en &&
      next_st.cnt > {1'b0, next_st.regs.thr};
    next_st.outs.cmp0_irq = next_st.regs.cmp0_en &&
      $signed(next_st.last) > $signed(next_st.regs.cmp0_lvl);
    next_st.outs.cmp1_irq = next_st.regs.cmp1_en &&
      $signed(next_st.last) > $signed(next_st.regs.cmp1_lvl);
    next_st.outs.dma_req = next_st.regs.rx_en && next_st.cnt != 4'h0;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.regs.clk_div <= DIV_RESET;
      st.regs.osr_sel <= OSR_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.outs.prdata;
  assign pready = st.outs.pready;
  assign pslverr = st.outs.pslverr;
  assign modulator_clock = st.outs.modulator_clock;
  assign bq_valid = st.outs.bq_valid;
  assign bq_data = st.outs.bq_data;
  assign fifo_irq = st.outs.fifo_irq;
  assign cmp0_irq = st.outs.cmp0_irq;
  assign cmp1_irq = st.outs.cmp1_irq;
  assign dma_req = st.outs.dma_req;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_count_bound: assert property (
    @(posedge core_clk) disable iff (!resetn) st.cnt <= FIFO_FULL)
    else $error("FIFO count above eight");

  a_full_overwrite: assert property (
    @(posedge core_clk) disable iff (!resetn)
    st.regs.conv_en && push && !pop_ok && st.cnt == FIFO_FULL
    |=> st.cnt == FIFO_FULL && st.rp == $past(st.rp) + 3'h1)
    else $error("Overwrite did not drop oldest");

  a_pop_read: assert property (
    @(posedge core_clk) disable iff (!resetn)
    st.regs.conv_en && pop_ok && !push
    |=> st.cnt == $past(st.cnt) - 4'h1 && prdata[31:16] == 16'h0000)
    else $error("Data read did not pop");

  a_empty_repeat: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rd_data && st.cnt == 4'h0
    |=> prdata == {16'h0000, $past(st.last)} && st.rp == $past(st.rp))
    else $error("Empty read changed state");

  a_fifo_irq_lvl: assert property (
    @(posedge core_clk) disable iff (!resetn)
    $rose(fifo_irq) |-> st.regs.irq_en && st.cnt > {1'b0, st.regs.thr})
    else $error("FIFO interrupt without cause");

  a_fifo_irq_hold: assert property (
    @(posedge core_clk) disable iff (!resetn)
    $fell(fifo_irq) |-> !st.regs.irq_en || $past(pop_ok) ||
      !$past(st.regs.conv_en) || $past(setup && pwrite))
    else $error("FIFO interrupt cleared without cause");

  a_dma_level: assert property (
    @(posedge core_clk) disable iff (!resetn)
    st.regs.conv_en && st.regs.rx_en && st.cnt != 4'h0 && !pop_ok
    ##1 st.regs.rx_en |-> dma_req)
    else $error("DMA request dropped with data");

  a_disable_reset: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !st.regs.conv_en |=> st.cnt == 4'h0 && st.wp == 3'h0 &&
      !st.outs.bq_valid)
    else $error("Disable left FIFO pointers");

  a_ratio_frame: assert property (
    @(posedge core_clk) disable iff (!resetn)
    st.bit_cnt <= osr_of(st.regs.osr_sel) - 9'h001 ||
      $changed(st.regs.osr_sel) || $past(setup && pwrite))
    else $error("Frame count past ratio");

  a_div_tick: assert property (
    @(posedge core_clk) disable iff (!resetn)
    tick |=> st.div_cnt == 8'h00)
    else $error("Divider did not wrap on tick");

endmodule
`default_nettype wire

// file: rtl/asdf_pkg.sv
// Constants and types for the audio delta-sigma converter control block
`default_nettype none
package asdf_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_FIFO_READ = 12'h000;
  localparam logic [11:0] OFS_CONV_EN = 12'h004;
  localparam logic [11:0] OFS_CLK_DIV = 12'h008;
  localparam logic [11:0] OFS_DEC_CTL = 12'h00c;
  localparam logic [11:0] OFS_INT_CTL = 12'h010;
  localparam logic [11:0] OFS_DMA_CTL = 12'h014;
  localparam logic [11:0] OFS_CMP0 = 12'h018;
  localparam logic [11:0] OFS_CMP1 = 12'h01c;
  localparam logic [11:0] OFS_LAST = 12'h01c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CONV_EN_BIT = 0;
  localparam int DIV_LSB = 0;
  localparam int OSR_LSB = 0;
  localparam int BQ_SEL_BIT = 8;
  localparam int IRQ_EN_BIT = 31;
  localparam int THR_LSB = 0;
  localparam int RX_EN_BIT = 0;
  localparam int CMP_EN_BIT = 31;
  localparam int CMP_LVL_LSB = 0;

  // ---------------------------------------------------------------
  // Sizes, reset values and ratios
  // ---------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL = 4'h8;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [3:0] OSR_RESET = 4'h0;
  localparam logic [8:0] OSR_64 = 9'h040;
  localparam logic [8:0] OSR_128 = 9'h080;
  localparam logic [8:0] OSR_192 = 9'h0c0;
  localparam logic [8:0] OSR_384 = 9'h180;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic conv_en;
    logic [7:0] clk_div;
    logic [3:0] osr_sel;
    logic bq_sel;
    logic irq_en;
    logic [2:0] thr;
    logic rx_en;
    logic cmp0_en;
    logic [15:0] cmp0_lvl;
    logic cmp1_en;
    logic [15:0] cmp1_lvl;
  } asdf_regs_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fifo_irq;
    logic cmp0_irq;
    logic cmp1_irq;
    logic dma_req;
    logic modulator_clock;
    logic bq_valid;
    logic [15:0] bq_data;
  } asdf_outs_t;

  typedef struct packed {
    asdf_regs_t regs;
    asdf_outs_t outs;
    logic [FIFO_DEPTH-1:0][15:0] mem;
    logic [2:0] wp;
    logic [2:0] rp;
    logic [3:0] cnt;
    logic [15:0] last;
    logic [7:0] div_cnt;
    logic [8:0] bit_cnt;
    logic [8:0] ones;
    logic bit_s1;
    logic bit_s2;
  } asdf_state_t;

endpackage
`default_nettype wire

// file: sim/asdf_mod_model.sv
// Modulator source and biquad stand-in facing the converter block
`default_nettype none
module asdf_mod_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Modulator side
  input wire logic modulator_clock,
  output logic modulator_bit,
  // Biquad side
  input wire logic bq_valid,
  input wire logic [15:0] bq_data,
  input wire logic pass,
  output logic bq_ret_valid,
  output logic [15:0] bq_ret_data,
  output logic [7:0] n_ret
);
  timeunit 1ns;
  timeprecision 100ps;

  // Full-scale positive bitstream once the modulator clock runs
  always_ff @(posedge modulator_clock or negedge resetn) begin
    if (!resetn) begin
      modulator_bit <= 1'b0;
    end else begin
      modulator_bit <= 1'b1;
    end
  end

  // Returns each sample only while pass is set; low byte numbers them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bq_ret_valid <= 1'b0;
      bq_ret_data <= 16'h0000;
      n_ret <= 8'h00;
    end else begin
      bq_ret_valid <= bq_valid && pass;
      if (bq_valid && pass) begin
        bq_ret_data <= {bq_data[15:8] ^ 8'h7f, n_ret};
        n_ret <= n_ret + 8'h01;
      end else begin
        bq_ret_data <= ~bq_ret_data;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the converter control block
`default_nettype none
module tb_top
  import asdf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, modulator_bit, modulator_clock, bq_valid;
  logic bq_ret_valid, fifo_irq, cmp0_irq, cmp1_irq, dma_req;
  logic [15:0] bq_data, bq_ret_data;
  logic pass = 1'b0;
  logic [7:0] n_ret;
  int cyc = 0;
  // Dividers that hold the modulator clock near 6.1 MHz and 4.0 MHz
  localparam logic [31:0] DIV_FAST = 32'h29;
  localparam logic [31:0] DIV_MID = 32'h3e;
  int fail_count = 0;
  int n_checks = 0;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  asdf_adc_ctrl u_asdf_adc_ctrl (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modulator_bit(modulator_bit), .modulator_clock(modulator_clock),
    .bq_valid(bq_valid), .bq_data(bq_data), .bq_ret_valid(bq_ret_valid),
    .bq_ret_data(bq_ret_data), .fifo_irq(fifo_irq), .cmp0_irq(cmp0_irq),
    .cmp1_irq(cmp1_irq), .dma_req(dma_req));

  asdf_mod_model u_asdf_mod_model (.core_clk(core_clk), .resetn(resetn),
    .modulator_clock(modulator_clock), .modulator_bit(modulator_bit),
    .bq_valid(bq_valid), .bq_data(bq_data), .pass(pass),
    .bq_ret_valid(bq_ret_valid), .bq_ret_data(bq_ret_data), .n_ret(n_ret));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Hold the access until the edge that samples pready high
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    check("apb ready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    check(what, d, exp);
  endtask

  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask

  task automatic wait_ret(input logic [7:0] target);
    int n;
    n = 0;
    while (n_ret !== target && n < 40000) begin
      @(negedge core_clk);
      n++;
    end
    check("returned samples", {24'h0, n_ret}, {24'h0, target});
  endtask

  task automatic next_pulse(output int t);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (bq_valid !== 1'b1 && n < 20000);
    t = cyc;
  endtask

  task automatic mclk_rise(output int t);
    int n;
    n = 0;
    while (modulator_clock !== 1'b0 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    while (modulator_clock !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    t = cyc;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] m [8] = '{32'h0, 32'h1, 32'hff, 32'h10f, 32'h8000_0007,
                           32'h1, 32'h8000_ffff, 32'h8000_ffff};
    logic [31:0] d;
    logic e;
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset value", 12'(4 * i), 32'h0);
    end
    for (int i = 7; i > 0; i--) begin
      wr(12'(4 * i), 32'hffff_ffff);
    end
    for (int i = 1; i < 8; i++) begin
      rd_chk("field mask", 12'(4 * i), m[i]);
    end
    for (int i = 1; i < 8; i++) begin
      wr(12'(4 * i), 32'h0);
    end
    apb(1'b0, 12'h020, 32'h0, d, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", d, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_fifo();
    wr(OFS_CLK_DIV, DIV_FAST);
    wr(OFS_DEC_CTL, 32'h100);
    wr(OFS_INT_CTL, 32'h8000_0007);
    wr(OFS_DMA_CTL, 32'h1);
    wr(OFS_CONV_EN, 32'h1);
    pass <= 1'b1;
    wait_ret(8'd10);
    @(posedge core_clk);
    pass <= 1'b0;
    settle();
    check("dma request full", {31'h0, dma_req}, 32'h1);
    check("level irq full", {31'h0, fifo_irq}, 32'h1);
    rd_chk("oldest kept", OFS_FIFO_READ, 32'h0000_0002);
    settle();
    check("level irq after pop", {31'h0, fifo_irq}, 32'h0);
    for (int i = 3; i < 10; i++) begin
      rd_chk("pop order", OFS_FIFO_READ, 32'(i));
    end
    settle();
    check("dma request empty", {31'h0, dma_req}, 32'h0);
    rd_chk("read past empty", OFS_FIFO_READ, 32'h9);
    wr(OFS_CMP0, 32'h8000_0005);
    wr(OFS_CMP1, 32'h8000_0009);
    settle();
    check("cmp0 above", {31'h0, cmp0_irq}, 32'h1);
    check("cmp1 equal", {31'h0, cmp1_irq}, 32'h0);
    wr(OFS_CMP1, 32'h8000_0008);
    settle();
    check("cmp1 above", {31'h0, cmp1_irq}, 32'h1);
    $display("t_fifo done");
  endtask

  task automatic t_drop();
    pass <= 1'b1;
    wait_ret(8'd12);
    @(posedge core_clk);
    pass <= 1'b0;
    wr(OFS_INT_CTL, 32'h8000_0000);
    settle();
    check("level irq thr0", {31'h0, fifo_irq}, 32'h1);
    wr(OFS_INT_CTL, 32'h0);
    settle();
    check("irq disabled", {31'h0, fifo_irq}, 32'h0);
    check("dma two held", {31'h0, dma_req}, 32'h1);
    wr(OFS_CONV_EN, 32'h0);
    settle();
    check("dma after stop", {31'h0, dma_req}, 32'h0);
    check("mod clock stop", {31'h0, modulator_clock}, 32'h0);
    rd_chk("stopped read", OFS_FIFO_READ, 32'h9);
    $display("t_drop done");
  endtask

  task automatic t_ratio();
    logic [31:0] decimation_ratio [4] = '{32'd64, 32'd128, 32'd192, 32'd384};
    int t0, t1;
    wr(OFS_CONV_EN, 32'h1);
    next_pulse(t0);
    for (int c = 0; c < 4; c++) begin
      // Switch just after a frame ends so the next frame is whole
      if (c != 0) begin
        wr(OFS_DEC_CTL, 32'h100 | 32'(c));
      end
      next_pulse(t1);
      check("sample spacing", 32'(t1 - t0), DIV_FAST * decimation_ratio[c]);
      t0 = t1;
    end
    $display("t_ratio done");
  endtask

  task automatic t_direct();
    int t0, t1, n;
    wr(OFS_CLK_DIV, DIV_MID);
    mclk_rise(t0);
    mclk_rise(t0);
    mclk_rise(t1);
    check("modulator period", 32'(t1 - t0), DIV_MID);
    wr(OFS_DEC_CTL, 32'h0);
    n = 0;
    while (dma_req !== 1'b1 && n < 10000) begin
      @(negedge core_clk);
      n++;
    end
    check("direct request", {31'h0, dma_req}, 32'h1);
    rd_chk("direct sample", OFS_FIFO_READ, 32'h0000_7fff);
    $display("t_direct done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_fifo();
    t_drop();
    t_ratio();
    t_direct();
    final_report();
  end

  initial begin
    #340000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
